// ===== rtl/dio_port_regs.svh
// Register offsets, field positions and reset values of the digital I/O port.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef DIO_PORT_REGS_SVH
`define DIO_PORT_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_DIRECTION 12'h000
`define OFS_DRIVE_MODE 12'h004
`define OFS_OUT_DATA 12'h008
`define OFS_IN_DATA 12'h00C
`define OFS_PFI_CTRL 12'h010
`define OFS_EVENT_COUNT 12'h014
`define OFS_ACQ_STATUS 12'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFI_CTRL_FUNC_BIT 0
`define PFI_CTRL_RISING_BIT 1
`define PFI_CTRL_ARM_BIT 2
`define PFI_CTRL_CLR_CNT_BIT 3
`define ACQ_STATUS_WAIT_BIT 0
`define ACQ_STATUS_FIRED_BIT 1
`define LANE_W 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DIRECTION 12'h000
`define RST_DRIVE_MODE 12'h000
`define RST_OUT_DATA 12'h000
`define RST_COUNT 32'h0000_0000
`define RST_PFI_RISING 1'b1
`define PFI_IDLE_LEVEL 1'b1

`endif

// ===== rtl/dio_port_pkg.sv
// Types shared by the digital I/O port with edge counter.
// Assumes the register header is on the include path.
package dio_port_pkg;

  typedef enum logic [1:0] {
    TRIG_IDLE = 2'b00,
    TRIG_WAIT = 2'b01,
    TRIG_FIRED = 2'b10
  } trig_state_t;

  typedef enum logic {
    PFI_FUNC_TRIGGER = 1'b0,
    PFI_FUNC_COUNTER = 1'b1
  } pfi_func_t;

  typedef struct packed {
    logic [7:0] port_a;
    logic [3:0] port_b;
  } line_vec_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// ===== rtl/dio_port.sv
// Twelve-line digital I/O port with a programmable function input that acts
// as acquisition start trigger or 32-bit falling-edge counter, plus 5 V gate.
// Assumes an APB master on clk_sys and external pull-ups on every line.
//
// Contract
// - Twelve lines: eight port A, four port B
// - Each line has its own direction bit
// - Reset leaves all lines undriven inputs
// - Reset drive mode is open-drain
// - Push-pull drive selectable per line
// - Line transfers only on software register access
// - Function select: trigger or event counter
// - Acquisition held until selected edge seen
// - Trigger polarity rising or falling selectable
// - Counter increments on each falling edge
// - Auxiliary 5 V disabled during USB suspend
`timescale 1ns/100ps
`default_nettype none
`include "dio_port_regs.svh"

module dio_port #(
  parameter int LINES_A = 8,
  parameter int LINES_B = 4,
  parameter int COUNT_W = 32,
  parameter bit PUSH_PULL_SUPPORTED = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LINES_A-1:0] port_a_lines_i,
  output logic [LINES_A-1:0] port_a_lines_o,
  output logic [LINES_A-1:0] port_a_lines_oe,
  input wire logic [LINES_B-1:0] port_b_lines_i,
  output logic [LINES_B-1:0] port_b_lines_o,
  output logic [LINES_B-1:0] port_b_lines_oe,
  input wire logic programmable_function_input,
  input wire logic usb_suspend,
  output logic aux_5v_enable,
  output logic acquisition_start_trigger,
  output logic acquisition_waiting
);

  localparam int LINES = LINES_A + LINES_B;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  dio_port_pkg::apb_req_t req;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign pready = 1'b1;
  assign wr_en = req.psel && req.penable && req.pwrite;
  assign rd_en = req.psel && req.penable && !req.pwrite;

  always_comb begin
    unique case (req.paddr)
      `OFS_DIRECTION, `OFS_DRIVE_MODE, `OFS_OUT_DATA, `OFS_IN_DATA,
      `OFS_PFI_CTRL, `OFS_EVENT_COUNT, `OFS_ACQ_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = req.psel && req.penable && !addr_ok;

  // ----------------------------------------
  // Line configuration and output data
  // ----------------------------------------
  logic [LINES-1:0] direction_q;
  logic [LINES-1:0] drive_mode_q;
  logic [LINES-1:0] out_data_q;
  logic [LINES-1:0] in_data_q;
  logic [LINES-1:0] wmask;

  // Byte lanes 0 and 1 cover the twelve line bits
  assign wmask = {{(LINES-`LANE_W){pstrb[1]}}, {`LANE_W{pstrb[0]}}};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      direction_q <= LINES'(`RST_DIRECTION);
    end else if (wr_en && req.paddr == `OFS_DIRECTION) begin
      direction_q <= (direction_q & ~wmask) | (req.pwdata[LINES-1:0] & wmask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drive_mode_q <= LINES'(`RST_DRIVE_MODE);
    end else if (wr_en && req.paddr == `OFS_DRIVE_MODE && PUSH_PULL_SUPPORTED) begin
      drive_mode_q <= (drive_mode_q & ~wmask) | (req.pwdata[LINES-1:0] & wmask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_data_q <= LINES'(`RST_OUT_DATA);
    end else if (wr_en && req.paddr == `OFS_OUT_DATA) begin
      out_data_q <= (out_data_q & ~wmask) | (req.pwdata[LINES-1:0] & wmask);
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [LINES-1:0] pin_o;
  logic [LINES-1:0] pin_oe;

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      // Open-drain lines only ever drive low
      assign pin_o[gi] = drive_mode_q[gi] ? out_data_q[gi] : 1'b0;
      assign pin_oe[gi] = direction_q[gi] && (drive_mode_q[gi] || !out_data_q[gi]);
    end
  endgenerate

  assign port_a_lines_o = pin_o[LINES_A-1:0];
  assign port_a_lines_oe = pin_oe[LINES_A-1:0];
  assign port_b_lines_o = pin_o[LINES-1:LINES_A];
  assign port_b_lines_oe = pin_oe[LINES-1:LINES_A];

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [LINES-1:0] line_meta_q;
  logic [LINES-1:0] line_sync_q;
  dio_port_pkg::line_vec_t raw_lines;
  logic pfi_meta_q;
  logic pfi_sync_q;
  logic pfi_prev_q;
  logic usb_meta_q;
  logic usb_sync_q;

  assign raw_lines = '{port_a: port_a_lines_i, port_b: port_b_lines_i};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      line_meta_q <= '0;
      line_sync_q <= '0;
    end else begin
      line_meta_q <= {raw_lines.port_b, raw_lines.port_a};
      line_sync_q <= line_meta_q;
    end
  end

  // Sample taken only when software reads the input register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_data_q <= '0;
    end else if (req.psel && !req.penable && !req.pwrite && req.paddr == `OFS_IN_DATA) begin
      in_data_q <= line_sync_q;
    end
  end

  // Reset to the pulled-up idle level, so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pfi_meta_q <= `PFI_IDLE_LEVEL;
      pfi_sync_q <= `PFI_IDLE_LEVEL;
    end else begin
      pfi_meta_q <= programmable_function_input;
      pfi_sync_q <= pfi_meta_q;
    end
  end

  // Edge history, fed only from the second synchroniser stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pfi_prev_q <= `PFI_IDLE_LEVEL;
    end else begin
      pfi_prev_q <= pfi_sync_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      usb_meta_q <= 1'b0;
      usb_sync_q <= 1'b0;
    end else begin
      usb_meta_q <= usb_suspend;
      usb_sync_q <= usb_meta_q;
    end
  end

  // ----------------------------------------
  // Function input control
  // ----------------------------------------
  dio_port_pkg::pfi_func_t func_q;
  logic rising_sel_q;
  logic rise_evt;
  logic fall_evt;
  logic edge_hit;
  logic ctrl_wr;

  assign rise_evt = pfi_sync_q && !pfi_prev_q;
  assign fall_evt = !pfi_sync_q && pfi_prev_q;
  assign edge_hit = rising_sel_q ? rise_evt : fall_evt;
  assign ctrl_wr = wr_en && req.paddr == `OFS_PFI_CTRL && pstrb[0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      func_q <= dio_port_pkg::PFI_FUNC_TRIGGER;
    end else if (ctrl_wr) begin
      func_q <= dio_port_pkg::pfi_func_t'(req.pwdata[`PFI_CTRL_FUNC_BIT]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rising_sel_q <= `RST_PFI_RISING;
    end else if (ctrl_wr) begin
      rising_sel_q <= req.pwdata[`PFI_CTRL_RISING_BIT];
    end
  end

  // ----------------------------------------
  // Start trigger
  // ----------------------------------------
  dio_port_pkg::trig_state_t trig_q;
  logic arm_req;

  // Arming is ignored when the same write selects counter duty
  assign arm_req = ctrl_wr && req.pwdata[`PFI_CTRL_ARM_BIT] &&
    dio_port_pkg::pfi_func_t'(req.pwdata[`PFI_CTRL_FUNC_BIT]) == dio_port_pkg::PFI_FUNC_TRIGGER;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trig_q <= dio_port_pkg::TRIG_IDLE;
    end else begin
      unique case (trig_q)
        dio_port_pkg::TRIG_IDLE: begin
          if (arm_req) begin
            trig_q <= dio_port_pkg::TRIG_WAIT;
          end
        end
        dio_port_pkg::TRIG_WAIT: begin
          // Leaving trigger duty while waiting disarms
          if (func_q != dio_port_pkg::PFI_FUNC_TRIGGER) begin
            trig_q <= dio_port_pkg::TRIG_IDLE;
          end else if (edge_hit) begin
            trig_q <= dio_port_pkg::TRIG_FIRED;
          end
        end
        dio_port_pkg::TRIG_FIRED: begin
          trig_q <= arm_req ? dio_port_pkg::TRIG_WAIT : dio_port_pkg::TRIG_IDLE;
        end
        default: trig_q <= dio_port_pkg::TRIG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acquisition_start_trigger <= 1'b0;
    end else begin
      acquisition_start_trigger <= trig_q == dio_port_pkg::TRIG_WAIT &&
        func_q == dio_port_pkg::PFI_FUNC_TRIGGER && edge_hit;
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  assign acquisition_waiting = trig_q == dio_port_pkg::TRIG_WAIT;

  // ----------------------------------------
  // Event counter
  // ----------------------------------------
  logic [COUNT_W-1:0] count_q;
  logic fired_q;
  logic fired_clr;

  assign fired_clr = wr_en && req.paddr == `OFS_ACQ_STATUS && req.pwdata[`ACQ_STATUS_FIRED_BIT];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_q <= COUNT_W'(`RST_COUNT);
    end else if (func_q == dio_port_pkg::PFI_FUNC_COUNTER && fall_evt) begin
      count_q <= count_q + 1'b1;
    end else if (ctrl_wr && req.pwdata[`PFI_CTRL_CLR_CNT_BIT]) begin
      count_q <= COUNT_W'(`RST_COUNT);
    end
  end

  // Sticky fired flag; an edge in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fired_q <= 1'b0;
    end else if (acquisition_start_trigger) begin
      fired_q <= 1'b1;
    end else if (fired_clr) begin
      fired_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Auxiliary supply gate
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aux_5v_enable <= 1'b0;
    end else begin
      aux_5v_enable <= !usb_sync_q;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (req.paddr)
      `OFS_DIRECTION: rdata_d[LINES-1:0] = direction_q;
      `OFS_DRIVE_MODE: rdata_d[LINES-1:0] = drive_mode_q;
      `OFS_OUT_DATA: rdata_d[LINES-1:0] = out_data_q;
      `OFS_IN_DATA: rdata_d[LINES-1:0] = in_data_q;
      `OFS_PFI_CTRL: begin
        rdata_d[`PFI_CTRL_FUNC_BIT] = func_q;
        rdata_d[`PFI_CTRL_RISING_BIT] = rising_sel_q;
      end
      `OFS_EVENT_COUNT: rdata_d[COUNT_W-1:0] = count_q;
      `OFS_ACQ_STATUS: begin
        rdata_d[`ACQ_STATUS_WAIT_BIT] = acquisition_waiting;
        rdata_d[`ACQ_STATUS_FIRED_BIT] = fired_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  assign prdata = rd_en ? rdata_d : 32'h0000_0000;

endmodule // dio_port

`default_nettype wire

// ===== testbench/dio_port_props.sv
// Concurrent checks on the ports of the digital I/O port.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dio_port_props #(
  parameter int LINES_A = 8,
  parameter int LINES_B = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [LINES_A-1:0] port_a_lines_o,
  input wire logic [LINES_A-1:0] port_a_lines_oe,
  input wire logic [LINES_B-1:0] port_b_lines_o,
  input wire logic [LINES_B-1:0] port_b_lines_oe,
  input wire logic programmable_function_input,
  input wire logic usb_suspend,
  input wire logic aux_5v_enable,
  input wire logic acquisition_start_trigger,
  input wire logic acquisition_waiting
);
  logic wr_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  always_ff @(posedge clk_sys) begin
    wr_q <= psel && penable && pwrite;
  end
  // ----
  // Sequences
  // ----
  sequence s_pin_edge;
    $past(programmable_function_input, 3) != $past(programmable_function_input, 7);
  endsequence
  sequence s_line_change;
    !$stable({port_a_lines_o, port_a_lines_oe, port_b_lines_o, port_b_lines_oe});
  endsequence
  // ----
  // Properties
  // ----
  AST_RESET_UNDRIVEN: assert property (disable iff (1'b0)
    $past(reset) |-> port_a_lines_oe == '0 && port_b_lines_oe == '0)
    else $error("line driven during reset");
  AST_LINES_BY_WRITE: assert property (s_line_change |-> wr_q)
    else $error("line drive changed without a register write");
  AST_READ_IDLE: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("read data outside a read access");
  AST_ERR_ACCESS: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  AST_PULSE_ONE: assert property (acquisition_start_trigger |=> !acquisition_start_trigger)
    else $error("start pulse longer than one cycle");
  AST_PULSE_ARMED: assert property (acquisition_start_trigger |-> $past(acquisition_waiting))
    else $error("start pulse while not waiting");
  AST_PULSE_EDGE: assert property (acquisition_start_trigger |-> s_pin_edge)
    else $error("start pulse without an input edge");
  AST_AUX_OFF: assert property (usb_suspend [*5] |-> !aux_5v_enable)
    else $error("aux supply on in suspend");
  AST_AUX_ON: assert property (!usb_suspend [*5] |-> aux_5v_enable)
    else $error("aux supply off while awake");
endmodule // dio_port_props
bind dio_port dio_port_props #(.LINES_A(LINES_A), .LINES_B(LINES_B)) u_props (
  .clk_sys(clk_sys),
  .reset(reset),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pslverr(pslverr),
  .port_a_lines_o(port_a_lines_o),
  .port_a_lines_oe(port_a_lines_oe),
  .port_b_lines_o(port_b_lines_o),
  .port_b_lines_oe(port_b_lines_oe),
  .programmable_function_input(programmable_function_input),
  .usb_suspend(usb_suspend),
  .aux_5v_enable(aux_5v_enable),
  .acquisition_start_trigger(acquisition_start_trigger),
  .acquisition_waiting(acquisition_waiting)
);
`default_nettype wire

// ===== testbench/dio_line_model.sv
// External side of the twelve lines: pull-ups and switch drivers.
// Assumes the design splits each line into drive value and enable.
`timescale 1ns/100ps
`default_nettype none
module dio_line_model (
  input wire dio_port_pkg::line_vec_t pin_o,
  input wire dio_port_pkg::line_vec_t pin_oe,
  input wire dio_port_pkg::line_vec_t ext_en,
  input wire dio_port_pkg::line_vec_t ext_val,
  output var dio_port_pkg::line_vec_t level
);
  // Device drive wins, then the switch, else the pull-up
  assign level = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule // dio_line_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench of the digital I/O port over APB.
// Assumes the package, register header and line model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "dio_port_regs.svh"
module testbench;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, oe_w, o_w, lv_w;
  logic [3:0] pstrb;
  logic [7:0] port_a_lines_i, port_a_lines_o, port_a_lines_oe;
  logic [3:0] port_b_lines_i, port_b_lines_o, port_b_lines_oe;
  logic programmable_function_input, usb_suspend, aux_5v_enable;
  logic acquisition_start_trigger, acquisition_waiting;
  dio_port_pkg::line_vec_t ext_en, ext_val, level;
  int miscompares, cmp_count;
  assign port_a_lines_i = level.port_a;
  assign port_b_lines_i = level.port_b;
  assign oe_w = {20'h0_0000, port_b_lines_oe, port_a_lines_oe};
  assign o_w = {20'h0_0000, port_b_lines_o, port_a_lines_o};
  assign lv_w = {20'h0_0000, level.port_b, level.port_a};
  dio_port dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .port_a_lines_i(port_a_lines_i),
    .port_a_lines_o(port_a_lines_o),
    .port_a_lines_oe(port_a_lines_oe),
    .port_b_lines_i(port_b_lines_i),
    .port_b_lines_o(port_b_lines_o),
    .port_b_lines_oe(port_b_lines_oe),
    .programmable_function_input(programmable_function_input),
    .usb_suspend(usb_suspend),
    .aux_5v_enable(aux_5v_enable),
    .acquisition_start_trigger(acquisition_start_trigger),
    .acquisition_waiting(acquisition_waiting)
  );
  dio_line_model lines (
    .pin_o({port_a_lines_o, port_b_lines_o}),
    .pin_oe({port_a_lines_oe, port_b_lines_oe}),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .level(level)
  );
  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  task automatic chk1(input logic s, input logic x);
    chk({31'h0000_0000, s}, {31'h0000_0000, x});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
    chk1(e, xe);
    #1;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    cyc(4);
    chk(oe_w, 32'h0000_0000);
    rd(`OFS_DIRECTION, 32'h0000_0000, 1'b0);
    rd(`OFS_DRIVE_MODE, 32'h0000_0000, 1'b0);
    rd(`OFS_PFI_CTRL, 32'h0000_0002, 1'b0);
    rd(12'h01C, 32'h0000_0000, 1'b1);
    chk1(aux_5v_enable, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_drive;
    wr(`OFS_OUT_DATA, 32'h0000_0A53);
    wr(`OFS_DIRECTION, 32'h0000_0FFF);
    chk(oe_w, 32'h0000_05AC);
    chk(lv_w, 32'h0000_0A53);
    wr(`OFS_DRIVE_MODE, 32'h0000_0FFF);
    wr(`OFS_DIRECTION, 32'h0000_00F0);
    chk(oe_w, 32'h0000_00F0);
    chk(o_w, 32'h0000_0A53);
    chk(lv_w, 32'h0000_0F5F);
    wr(`OFS_DIRECTION, 32'h0000_0000);
    @(posedge clk_sys);
    ext_en <= 12'hFFF;
    ext_val <= {8'hC6, 4'h3};
    cyc(4);
    rd(`OFS_IN_DATA, 32'h0000_03C6, 1'b0);
    @(posedge clk_sys);
    ext_en <= 12'h000;
    $display("test drive done");
  endtask
  task automatic t_trigger;
    logic pol;
    int n;
    for (int i = 0; i < 2; i++) begin
      pol = i[0];
      @(posedge clk_sys);
      programmable_function_input <= pol;
      cyc(8);
      wr(`OFS_PFI_CTRL, {28'h000_0000, 1'b0, 1'b1, pol, 1'b0});
      @(posedge clk_sys);
      programmable_function_input <= ~pol;
      cyc(8);
      chk1(acquisition_waiting, 1'b1);
      rd(`OFS_ACQ_STATUS, 32'h0000_0001, 1'b0);
      @(posedge clk_sys);
      programmable_function_input <= pol;
      n = 0;
      while (acquisition_start_trigger !== 1'b1 && n < 12) begin
        cyc(1);
        n++;
      end
      chk1(acquisition_start_trigger, 1'b1);
      chk(n, 3);
      rd(`OFS_ACQ_STATUS, 32'h0000_0002, 1'b0);
      wr(`OFS_ACQ_STATUS, 32'h0000_0002);
      rd(`OFS_ACQ_STATUS, 32'h0000_0000, 1'b0);
    end
    $display("test trigger done");
  endtask
  task automatic t_counter;
    rd(`OFS_EVENT_COUNT, 32'h0000_0000, 1'b0);
    wr(`OFS_PFI_CTRL, 32'h0000_000D);
    chk1(acquisition_waiting, 1'b0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      programmable_function_input <= 1'b0;
      cyc(4);
      @(posedge clk_sys);
      programmable_function_input <= 1'b1;
      cyc(4);
    end
    rd(`OFS_EVENT_COUNT, 32'h0000_0005, 1'b0);
    $display("test counter done");
  endtask
  task automatic t_suspend;
    @(posedge clk_sys);
    usb_suspend <= 1'b1;
    cyc(6);
    chk1(aux_5v_enable, 1'b0);
    @(posedge clk_sys);
    usb_suspend <= 1'b0;
    cyc(6);
    chk1(aux_5v_enable, 1'b1);
    $display("test suspend done");
  endtask
  task automatic t_midreset;
    wr(`OFS_DIRECTION, 32'h0000_0FFF);
    chk(oe_w, 32'h0000_0FFF);
    @(posedge clk_sys);
    reset <= 1'b1;
    cyc(3);
    chk(oe_w, 32'h0000_0000);
    @(posedge clk_sys);
    reset <= 1'b0;
    cyc(2);
    chk(oe_w, 32'h0000_0000);
    rd(`OFS_DIRECTION, 32'h0000_0000, 1'b0);
    rd(`OFS_DRIVE_MODE, 32'h0000_0000, 1'b0);
    rd(`OFS_EVENT_COUNT, 32'h0000_0000, 1'b0);
    $display("test mid reset done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----
  // Clock, watchdog and sequence
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h3;
    programmable_function_input = 1'b1;
    usb_suspend = 1'b0;
    ext_en = 12'h000;
    ext_val = 12'h000;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_drive();
    t_trigger();
    t_counter();
    t_suspend();
    t_midreset();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
